/* File: bench/link_checker.sv */
`default_nettype none
module link_checker (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic sck,
   input wire logic sel_n,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic io3,
   input wire logic ded_rst_n
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   logic       sck_q_r;
   logic [3:0] rise_cnt_r;

   // Previous serial clock level
   always_ff @(posedge ref_clk_i) begin
      sck_q_r <= sck;
   end

   // Serial clock rises seen within the current frame
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || sel_n) begin
         rise_cnt_r <= 4'h0;
      end else if (sck && !sck_q_r) begin
         rise_cnt_r <= rise_cnt_r + 4'h1;
      end
   end

   AST_DESEL_HIGH_Z: assert property (sel_n [*5] |-> !so_oe)
      else $error("output driven while deselected");
   AST_PAUSE_HIGH_Z: assert property (
      (!io3 && !sel_n) [*5] |-> !so_oe)
      else $error("output driven while paused");
   AST_RESET_HIGH_Z: assert property ((!ded_rst_n) [*5] |-> !so_oe)
      else $error("output driven in reset");
   AST_IDLE_SCK_LOW: assert property (sel_n |-> !sck)
      else $error("serial clock high outside frame");
   AST_SI_HELD_HIGH: assert property (
      sck && $past(sck) |-> $stable(si))
      else $error("input data moved in high phase");
   AST_SO_ON_FALL: assert property (
      !sel_n && $past(!sel_n) && $changed(so) |-> $fell(sck))
      else $error("output data moved off falling edge");
   AST_PAUSE_STOPS_SCK: assert property (!io3 && !sel_n |-> !sck)
      else $error("serial clock ran during pause");
   AST_OE_SELECTED: assert property ($rose(so_oe) |-> !sel_n)
      else $error("output enabled while deselected");
   AST_EIGHT_RISES: assert property (
      $rose(sel_n) |-> rise_cnt_r == 4'h8)
      else $error("frame did not hold eight clock rises");

   // Main scenarios
   cover property ($rose(sel_n));
   cover property (!io3 && !sel_n);
   cover property (!ded_rst_n);
endmodule // link_checker
`default_nettype wire

/* File: bench/tb_top.sv */
`default_nettype none
module tb_top;
   import pin_mux_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic       ref_clk_i = 1'b0;
   logic       rst_i     = 1'b1;
   logic       start = 0, pause = 0, reset_req = 0, io3_is_reset = 0;
   logic       use_ded = 0, quad = 0, flash_busy = 0, sel = 0, fitted = 0;
   logic [7:0] tx_byte  = 8'h00;
   logic [7:0] func_cfg = 8'h00;
   logic       reset_mode, paused, rx_valid, done, refused, busy;
   logic [7:0] rx_data, rx_byte;
   pin_fn_e    pin_fn;
   int         miscompares = 0;
   int         compares    = 0;

   // Reference clock
   always #2.5 ref_clk_i = ~ref_clk_i;

   flash_link_if lk ();

   flash_host_end i_flash_host_end (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(lk), .start_i(start),
      .tx_byte_i(tx_byte), .pause_i(pause), .reset_req_i(reset_req),
      .io3_is_reset_i(io3_is_reset), .use_dedicated_reset_i(use_ded),
      .quad_i(quad), .flash_busy_i(flash_busy), .rx_byte_o(rx_byte),
      .done_o(done), .refused_o(refused), .busy_o(busy));

   flash_pin_end i_flash_pin_end (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(lk),
      .quad_io_enable_i(quad), .pin_function_select_i(sel),
      .func_cfg_i(func_cfg), .dedicated_reset_fitted_i(fitted),
      .pin_function_o(pin_fn), .reset_mode_o(reset_mode),
      .paused_o(paused), .rx_valid_o(rx_valid), .rx_data_o(rx_data));

   link_checker i_link_checker (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .sck(lk.sck), .sel_n(lk.sel_n),
      .si(lk.si), .so(lk.so), .so_oe(lk.so_oe), .io3(lk.io3),
      .ded_rst_n(lk.ded_rst_n));

   task automatic report_and_stop();
      if (miscompares == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp_fn(input pin_fn_e got, input pin_fn_e exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk_i);
   endtask

   // One host byte transfer, waits for completion
   task automatic send(input logic [7:0] b);
      int n;
      n = 0;
      start = 1'b1;
      tx_byte = b;
      tick(1);
      start = 1'b0;
      tick(1);
      cmp({7'h0, busy}, 8'h01);
      while (done !== 1'b1 && n < 400) begin
         tick(1);
         n++;
      end
      cmp({7'h0, done}, 8'h01);
      tick(4);
      cmp({7'h0, busy}, 8'h00);
   endtask

   // Host reset request, checks reset mode and refusal
   task automatic pulse_reset(input logic exp_mode);
      logic seen;
      seen = 1'b0;
      reset_req = 1'b1;
      tick(1);
      reset_req = 1'b0;
      // Refusal pulse stands in the cycle right after the request
      repeat (8) begin
         seen |= refused;
         tick(1);
      end
      cmp({7'h0, reset_mode}, {7'h0, exp_mode});
      cmp({7'h0, seen}, {7'h0, flash_busy});
      tick(30);
      cmp({7'h0, reset_mode}, 8'h00);
   endtask

   // Watchdog against a hung handshake
   initial begin
      #50000;
      miscompares++;
      report_and_stop();
   end

   initial begin
      tick(4);
      rst_i = 1'b0;
      tick(4);
      // Every combination of pin function inputs
      for (int i = 0; i < 16; i++) begin
         {quad, fitted, func_cfg[0], sel} = i[3:0];
         tick(4);
         cmp_fn(pin_fn, quad ? PIN_DATA : (fitted && !func_cfg[0]) ?
            PIN_PAUSE : sel ? PIN_RESET : PIN_PAUSE);
         if (quad) cmp({7'h0, lk.io3_oe}, 8'h00);
      end
      {quad, fitted, func_cfg[0], sel} = 4'h4;
      tick(4);
      send(8'ha5);
      cmp(rx_data, 8'ha5);
      cmp({7'h0, lk.so_oe}, 8'h00);
      send(8'h3c);
      cmp(rx_data, 8'h3c);
      cmp(rx_byte, 8'ha5);
      fork
         send(8'h96);
         begin
            tick(20);
            pause = 1'b1;
            tick(30);
            cmp({7'h0, paused}, 8'h01);
            cmp({7'h0, lk.so_oe}, 8'h00);
            pause = 1'b0;
         end
      join
      cmp(rx_data, 8'h96);
      // First bit reads the pulled-up line, the rest echo the last byte
      cmp(rx_byte, 8'hbc);
      {fitted, sel, io3_is_reset} = 3'b011;
      tick(4);
      pulse_reset(1'b1);
      {fitted, sel, io3_is_reset, use_ded} = 4'b1001;
      tick(4);
      pulse_reset(1'b1);
      func_cfg = 8'h01;
      tick(4);
      pulse_reset(1'b0);
      func_cfg = 8'h00;
      flash_busy = 1'b1;
      pulse_reset(1'b0);
      flash_busy = 1'b0;
      send(8'h5a);
      cmp(rx_byte, 8'h80);
      send(8'h00);
      cmp(rx_byte, 8'hda);
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire

/* File: core/flash_host_end.sv */
`default_nettype none
module flash_host_end
   import pin_mux_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   flash_link_if.host             link,
   input  wire logic              start_i,
   input  wire logic [BYTE_W-1:0] tx_byte_i,
   input  wire logic              pause_i,
   input  wire logic              reset_req_i,
   input  wire logic              io3_is_reset_i,
   input  wire logic              use_dedicated_reset_i,
   input  wire logic              quad_i,
   input  wire logic              flash_busy_i,
   output logic [BYTE_W-1:0]      rx_byte_o,
   output logic                   done_o,
   output logic                   refused_o,
   output logic                   busy_o
);

   typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_END, ST_RST}
      host_state_e;

   host_state_e           st_r;
   logic [DIV_W-1:0]      div_r;
   logic                  div_done;
   logic [BIT_CNT_W-1:0]  bits_r;
   logic [BYTE_W-1:0]     tx_r;
   logic [BYTE_W-1:0]     rx_r;
   logic [RST_CNT_W-1:0]  rst_cnt_r;
   logic                  so_meta_r;
   logic                  so_sync_r;
   logic                  sck_r;
   logic                  sel_n_r;
   logic                  pause_n_r;
   logic                  rst_n_r;
   logic                  ded_n_r;
   logic                  done_r;
   logic                  refused_r;
   logic                  busy_r;
   logic                  io3_oe_r;

   assign div_done = div_r == DIV_W'(SCK_HALF_CYC - 1);

   // Serial output from the device passes two flip-flops
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         so_meta_r <= 1'b1;
         so_sync_r <= 1'b1;
      end else begin
         so_meta_r <= link.so_line;
         so_sync_r <= so_meta_r;
      end
   end

   // Half period divider; frozen while paused
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || st_r == ST_IDLE || div_done) begin
         div_r <= '0;
      end else if (!(st_r == ST_LOW && !pause_n_r)) begin  // [R5]
         div_r <= div_r + 1'b1;
      end
   end

   // Transfer sequencer
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE;
         sck_r <= 1'b0;
         sel_n_r <= 1'b1;
         bits_r <= '0;
         tx_r <= '0;
         rx_r <= '0;
         rst_cnt_r <= '0;
         done_r <= 1'b0;
         refused_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         refused_r <= 1'b0;
         unique case (st_r)
            ST_IDLE: begin
               if (reset_req_i && flash_busy_i) begin
                  refused_r <= 1'b1;                        // [R9]
               end else if (reset_req_i) begin
                  st_r <= ST_RST;
                  rst_cnt_r <= '0;
               end else if (start_i) begin
                  st_r <= ST_LOW;
                  sel_n_r <= 1'b0;
                  tx_r <= tx_byte_i;
                  bits_r <= '0;
               end
            end
            ST_LOW: begin
               // No rising clock edge while the pause pin is low
               if (div_done && pause_n_r) begin             // [R5] [R11]
                  sck_r <= 1'b1;
                  st_r <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (div_done) begin
                  sck_r <= 1'b0;
                  rx_r <= {rx_r[BYTE_W-2:0], so_sync_r};
                  tx_r <= {tx_r[BYTE_W-2:0], 1'b0};
                  bits_r <= bits_r + 1'b1;
                  st_r <= (bits_r == BIT_CNT_W'(BYTE_W - 1)) ?
                          ST_END : ST_LOW;
               end
            end
            ST_END: begin
               sel_n_r <= 1'b1;
               done_r <= 1'b1;
               st_r <= ST_IDLE;
            end
            ST_RST: begin
               rst_cnt_r <= rst_cnt_r + 1'b1;
               if (rst_cnt_r == RST_CNT_W'(RST_PULSE_CYC - 1)) begin
                  st_r <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Pause only while selected, between clock pulses
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pause_n_r <= 1'b1;
      end else begin
         pause_n_r <= !(pause_i && st_r == ST_LOW            // [R5]
                     && !(div_done && pause_n_r)           // [R13]
                     && !io3_is_reset_i);                  // [R7]
      end
   end

   // Reset drive on the chosen pin
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rst_n_r <= 1'b1;
         ded_n_r <= 1'b1;
      end else begin
         rst_n_r <= !(st_r == ST_RST && !use_dedicated_reset_i);
         ded_n_r <= !(st_r == ST_RST && use_dedicated_reset_i);
      end
   end

   // Busy flag and shared pin release, both registered
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         busy_r   <= 1'b0;
         io3_oe_r <= 1'b1;
      end else begin
         busy_r   <= st_r != ST_IDLE;
         io3_oe_r <= !quad_i;                              // [R1]
      end
   end

   assign link.sck       = sck_r;
   assign link.sel_n     = sel_n_r;
   assign link.si        = tx_r[BYTE_W-1];
   assign link.io3_drv   = pause_n_r & rst_n_r;
   assign link.io3_oe    = io3_oe_r;                         // [R1]
   assign link.ded_rst_n = ded_n_r;
   assign rx_byte_o      = rx_r;
   assign done_o         = done_r;
   assign refused_o      = refused_r;
   assign busy_o         = busy_r;

endmodule // flash_host_end
`default_nettype wire

/* File: core/flash_pin_end.sv */
// Notes on behaviour
// R1: Quad enable makes shared pin data only
// R2: No dedicated reset: select bit picks pause/reset
// R3: Dedicated reset enabled: shared pin is pause
// R4: Dedicated reset disabled: select bit picks function
// R5: Pause active low, suspends without losing sequence
// R6: Pause low and selected: output high impedance
// R7: Pause released: resume where it stopped
// R8: Reset low: reset mode, outputs high impedance
// R9: Host avoids reset during internal write
// R10: Config bit 0 set disables dedicated reset
// R11: Serial sampling and driving follow serial clock
// R12: Deselected: outputs high impedance, no data
// R13: Paused: clock edges ignored, counters frozen
`default_nettype none
module flash_pin_end
   import pin_mux_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   flash_link_if.device           link,
   input  wire logic              quad_io_enable_i,
   input  wire logic              pin_function_select_i,
   input  wire logic [FUNC_CFG_W-1:0] func_cfg_i,
   input  wire logic              dedicated_reset_fitted_i,
   output pin_fn_e                pin_function_o,
   output logic                   reset_mode_o,
   output logic                   paused_o,
   output logic                   rx_valid_o,
   output logic [BYTE_W-1:0]      rx_data_o
);

   // Reference clock domain state
   logic [3:0]          pin_meta_r;
   logic [3:0]          pin_sync_r;
   logic                sel_n_s;
   logic                io3_s;
   logic                ded_rst_n_s;
   logic                fitted_s;
   pin_fn_e             fn_r;
   pin_fn_e             fn_nxt;
   logic                ded_en_r;
   logic                reset_mode_r;
   logic                paused_r;
   logic                so_oe_r;
   logic                drive_meta_r;
   logic                drive_sync_r;
   logic                flag_meta_r;
   logic                flag_sync_r;
   logic                flag_seen_r;
   logic                rx_valid_r;
   logic [BYTE_W-1:0]   rx_data_r;

   // Link clock domain state
   logic                clr_link;
   logic                clr_cfg;
   pin_fn_e             fn_meta_k;
   pin_fn_e             fn_sync_k;
   logic                hold_k;
   logic [BIT_CNT_W-1:0] bit_cnt_r;
   logic [BYTE_W-1:0]   shift_r;
   logic [BYTE_W-1:0]   rx_byte_r;
   logic                rx_flag_r;
   logic                drive_r;
   logic                so_r;

   // Pins reach the reference domain through two flip-flops
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pin_meta_r <= 4'hf;
         pin_sync_r <= 4'hf;
      end else begin
         pin_meta_r <= {link.sel_n, link.io3, link.ded_rst_n,
                        dedicated_reset_fitted_i};
         pin_sync_r <= pin_meta_r;
      end
   end

   assign sel_n_s     = pin_sync_r[3];
   assign io3_s       = pin_sync_r[2];
   assign ded_rst_n_s = pin_sync_r[1];
   assign fitted_s    = pin_sync_r[0];

   // Selection of the shared pin function
   always_comb begin
      if (quad_io_enable_i) begin
         fn_nxt = PIN_DATA;                                 // [R1]
      end else if (fitted_s && !func_cfg_i[FUNC_RST_DIS_BIT]) begin
         fn_nxt = PIN_PAUSE;                                // [R3]
      end else if (pin_function_select_i) begin
         fn_nxt = PIN_RESET;                                // [R2] [R4]
      end else begin
         fn_nxt = PIN_PAUSE;                                // [R2] [R4]
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         fn_r     <= PIN_FN_RST;
         ded_en_r <= 1'b0;
      end else begin
         fn_r     <= fn_nxt;
         ded_en_r <= fitted_s && !func_cfg_i[FUNC_RST_DIS_BIT]; // [R10]
      end
   end

   // Reset mode from the dedicated pin or the shared pin
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         reset_mode_r <= 1'b1;
      end else begin
         reset_mode_r <= (ded_en_r && !ded_rst_n_s) ||
                         (fn_r == PIN_RESET && !io3_s);     // [R8]
      end
   end

   // Pause state seen while selected
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         paused_r <= 1'b0;
      end else begin
         paused_r <= fn_r == PIN_PAUSE && !io3_s && !sel_n_s; // [R5]
      end
   end

   // Drive request from the link side, level crossing
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         drive_meta_r <= 1'b0;
         drive_sync_r <= 1'b0;
      end else begin
         drive_meta_r <= drive_r;
         drive_sync_r <= drive_meta_r;
      end
   end

   // Output enable gated by select, pause and reset mode
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         so_oe_r <= 1'b0;
      end else begin
         so_oe_r <= drive_sync_r && !sel_n_s      // [R12]
                 && !reset_mode_r                 // [R8]
                 && !paused_r;                    // [R6]
      end
   end

   // Received byte flag crossing, rising edge gives one pulse
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         flag_meta_r <= 1'b0;
         flag_sync_r <= 1'b0;
         flag_seen_r <= 1'b0;
         rx_valid_r  <= 1'b0;
         rx_data_r   <= '0;
      end else begin
         flag_meta_r <= rx_flag_r;
         flag_sync_r <= flag_meta_r;
         flag_seen_r <= flag_sync_r;
         rx_valid_r  <= flag_sync_r && !flag_seen_r;
         if (flag_sync_r && !flag_seen_r) begin
            rx_data_r <= rx_byte_r;  // Stable for a whole byte time
         end
      end
   end

   // Link logic clears on deselect or reset mode
   assign clr_link = link.sel_n | reset_mode_r;             // [R12]
   assign clr_cfg  = reset_mode_r;

   // Pin function brought into the link domain
   always_ff @(posedge link.sck or posedge clr_cfg) begin
      if (clr_cfg) begin
         fn_meta_k <= PIN_FN_RST;
         fn_sync_k <= PIN_FN_RST;
      end else begin
         fn_meta_k <= fn_r;
         fn_sync_k <= fn_meta_k;
      end
   end

   // Pause is sampled with the serial clock it suspends
   assign hold_k = (fn_sync_k == PIN_PAUSE) && !link.io3;   // [R5]

   // Input sampling on the rising serial clock edge
   always_ff @(posedge link.sck or posedge clr_link) begin
      if (clr_link) begin
         bit_cnt_r <= '0;
         shift_r   <= '0;
      end else if (!hold_k) begin                           // [R13]
         bit_cnt_r <= bit_cnt_r + 1'b1;                     // [R11]
         shift_r   <= {shift_r[BYTE_W-2:0], link.si};       // [R11]
      end
   end

   // Completed byte and its flag; survive the end of a frame
   always_ff @(posedge link.sck or posedge clr_cfg) begin
      if (clr_cfg) begin
         rx_byte_r <= '0;
         rx_flag_r <= 1'b0;
      end else if (!hold_k && !link.sel_n) begin            // [R7]
         if (bit_cnt_r == BIT_CNT_W'(BYTE_W - 1)) begin
            rx_byte_r <= {shift_r[BYTE_W-2:0], link.si};
            rx_flag_r <= 1'b1;
         end else if (bit_cnt_r == '0) begin
            rx_flag_r <= 1'b0;
         end
      end
   end

   // Output driven on the falling edge, echoing the last byte
   always_ff @(negedge link.sck or posedge clr_link) begin
      if (clr_link) begin
         so_r    <= 1'b0;
         drive_r <= 1'b0;
      end else if (!hold_k) begin                           // [R13]
         so_r    <= rx_byte_r[BIT_CNT_W'(BYTE_W - 1) - bit_cnt_r]; // [R11]
         drive_r <= 1'b1;
      end
   end

   assign link.so        = so_r;
   assign link.so_oe     = so_oe_r;
   assign pin_function_o = fn_r;
   assign reset_mode_o   = reset_mode_r;
   assign paused_o       = paused_r;
   assign rx_valid_o     = rx_valid_r;
   assign rx_data_o      = rx_data_r;

endmodule // flash_pin_end
`default_nettype wire

/* File: pkg/flash_link_if.sv */
`default_nettype none
interface flash_link_if;
   logic sck;        // Serial clock, made by the host
   logic sel_n;      // Device select, active low
   logic si;         // Serial data into the device
   logic so;         // Serial data driven by the device
   logic so_oe;      // Device drives so
   logic so_line;    // Level of the serial output wire
   logic io3_drv;    // Host drive of the shared pin
   logic io3_oe;     // Host drives the shared pin
   logic io3;        // Level of the shared pin
   logic ded_rst_n;  // Dedicated reset pin, active low

   // Wire levels; both pins have a pull-up when undriven
   assign io3     = io3_oe ? io3_drv : 1'b1;
   assign so_line = so_oe ? so : 1'b1;

   modport device (
      input  sck,
      input  sel_n,
      input  si,
      input  io3,
      input  ded_rst_n,
      output so,
      output so_oe
   );

   modport host (
      output sck,
      output sel_n,
      output si,
      output io3_drv,
      output io3_oe,
      output ded_rst_n,
      input  so_line
   );
endinterface
`default_nettype wire

/* File: pkg/pin_mux_pkg.sv */
`default_nettype none
package pin_mux_pkg;

   // Data path widths
   localparam int BYTE_W     = 8;
   localparam int BIT_CNT_W  = 3;
   localparam int FUNC_CFG_W = 8;

   // Function configuration register: dedicated reset disable bit
   localparam int FUNC_RST_DIS_BIT = 0;

   // Reset values of configuration seen by the pin selector
   localparam logic QUAD_IO_ENABLE_RST      = 1'b0;
   localparam logic PIN_FUNCTION_SELECT_RST = 1'b0;

   // Host timing on the 200 MHz reference clock
   localparam int REF_CLK_MHZ  = 200;
   localparam int SCK_HALF_CYC = 4;            // Serial clock half period
   localparam int DIV_W        = 3;
   localparam int RST_PULSE_NS = 100;          // Least reset pulse width
   localparam int RST_PULSE_CYC =
      (RST_PULSE_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int RST_CNT_W    = 6;

   // Function of the shared fourth data pin
   typedef enum logic [1:0] {
      PIN_PAUSE,
      PIN_RESET,
      PIN_DATA
   } pin_fn_e;

   localparam pin_fn_e PIN_FN_RST = PIN_PAUSE;

endpackage
`default_nettype wire
